// [swcc_defines.vh]
`ifndef SWCC_DEFINES_VH
`define SWCC_DEFINES_VH

// ==========================================
// serial word layout
`define SWCC_WORD_BITS 24
`define SWCC_CMD_MSB 23
`define SWCC_CMD_LSB 20
`define SWCC_ADDR_MSB 19
`define SWCC_ADDR_LSB 16
`define SWCC_DATA_MSB 15
`define SWCC_DATA_LSB 0
`define SWCC_WIPER_MSB 9
`define SWCC_COUNT_BITS 6
`define SWCC_COUNT_MAX 6'h3f

// ==========================================
// widths and values
`define SWCC_WIPER_BITS 10
`define SWCC_STORE_BITS 16
`define SWCC_ADDR_BITS 4
`define SWCC_STORE_DEPTH 16
`define SWCC_WIPER_ADDR 4'h0
`define SWCC_MIDSCALE 10'h200
`define SWCC_FULLSCALE 10'h3ff
`define SWCC_ZEROSCALE 10'h000
`define SWCC_USER_RESET 16'h0000

// ==========================================
// instruction codes
`define SWCC_CMD_NOP 4'h0
`define SWCC_CMD_RESTORE 4'h1
`define SWCC_CMD_SAVE 4'h2
`define SWCC_CMD_STORE_DATA 4'h3
`define SWCC_CMD_DEC6DB 4'h4
`define SWCC_CMD_DEC6DB_ALL 4'h5
`define SWCC_CMD_DEC1 4'h6
`define SWCC_CMD_DEC1_ALL 4'h7
`define SWCC_CMD_RELOAD 4'h8
`define SWCC_CMD_READ_STORE 4'h9
`define SWCC_CMD_READ_WIPER 4'ha
`define SWCC_CMD_WRITE_WIPER 4'hb
`define SWCC_CMD_INC6DB 4'hc
`define SWCC_CMD_INC6DB_ALL 4'hd
`define SWCC_CMD_INC1 4'he
`define SWCC_CMD_INC1_ALL 4'hf

// ==========================================
// timing
`define SWCC_SAVE_TIME_US 25000
`define SWCC_CLK_PERIOD_NS 40
`define SWCC_SAVE_CYCLES ((`SWCC_SAVE_TIME_US * 1000) / `SWCC_CLK_PERIOD_NS)

`endif

// [swcc_host.sv]
`timescale 1ns/1ps
// ==========================================
// host model, link clock idles low between frames, 320 ns period
module swcc_host (
   input wire clock,
   input wire sdoLine,
   output logic spiClk,
   output logic chipSelectN,
   output logic serialIn
);
   initial begin
      spiClk = 1'b0;
      chipSelectN = 1'b1;
      serialIn = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // word out, word seen on the returned line sampled just before each rise
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      chipSelectN = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serialIn = w[i];
         tick(4);
         r[i] = sdoLine;
         spiClk = 1'b1;
         tick(4);
         spiClk = 1'b0;
      end
      tick(4);
      chipSelectN = 1'b1;
      serialIn = ~w[0];
      tick(8);
   endtask
   // select pulse with no clocks
   task automatic strobe();
      chipSelectN = 1'b0;
      tick(6);
      chipSelectN = 1'b1;
      tick(8);
   endtask
endmodule // swcc_host

// [swcc_nvstore.v]
`timescale 1ns/1ps
`include "swcc_defines.vh"
// ==========================================
// nonvolatile store model with timed programming
module swcc_nvstore #(
   parameter SAVE_CYCLES = `SWCC_SAVE_CYCLES
) (
   input wire clock,
   input wire resetn,
   input wire clockEnable,
   input wire writeStart,
   input wire [`SWCC_ADDR_BITS-1:0] writeAddr,
   input wire [`SWCC_STORE_BITS-1:0] writeData,
   input wire [`SWCC_ADDR_BITS-1:0] readAddr,
   output wire [`SWCC_STORE_BITS-1:0] readData,
   output wire [`SWCC_WIPER_BITS-1:0] savedWiper,
   output reg busy
);
   reg [`SWCC_STORE_BITS-1:0] mem_reg [0:`SWCC_STORE_DEPTH-1];
   reg [31:0] timer_reg;
   reg [`SWCC_ADDR_BITS-1:0] addr_reg;
   reg [`SWCC_STORE_BITS-1:0] data_reg;
   integer i;

   assign readData = mem_reg[readAddr];
   assign savedWiper = mem_reg[`SWCC_WIPER_ADDR][`SWCC_WIPER_MSB:0];

   // ==========================================
   // factory contents; reset stands in for power loss, so it leaves the array alone
   initial begin
      for (i = 0; i < `SWCC_STORE_DEPTH; i = i + 1) begin
         mem_reg[i] = `SWCC_USER_RESET;
      end
      mem_reg[`SWCC_WIPER_ADDR] = {6'h00, `SWCC_MIDSCALE};
   end

   // ==========================================
   // array written only when a timed save ends
   always @(posedge clock) begin
      if (clockEnable && busy && timer_reg >= SAVE_CYCLES) begin
         mem_reg[addr_reg] <= data_reg;
      end
   end

   // ==========================================
   // programming timer
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timer_reg <= 32'h00000000;
         addr_reg <= 4'h0;
         data_reg <= 16'h0000;
         busy <= 1'b0;
      end else if (clockEnable) begin
         if (!busy && writeStart) begin
            busy <= 1'b1;
            addr_reg <= writeAddr;
            data_reg <= writeData;
            timer_reg <= 32'h00000001;
         end else if (busy) begin
            if (timer_reg >= SAVE_CYCLES) begin
               busy <= 1'b0;
            end else begin
               timer_reg <= timer_reg + 32'h00000001;
            end
         end
      end
   end
endmodule // swcc_nvstore

// [swcc_sync.v]
`timescale 1ns/1ps
// ==========================================
// two flop synchroniser, first stage read only by the second
module swcc_sync #(
   parameter WIDTH = 5,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   input wire clock,
   input wire resetn,
   input wire clockEnable,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1_reg;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stage1_reg <= INIT;
         syncOut <= INIT;
      end else if (clockEnable) begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end
endmodule // swcc_sync

// [swcc_top.v]
`timescale 1ns/1ps
`include "swcc_defines.vh"

// Notes on behaviour
// - wiper code sets tap, zero at B, midscale middle, all ones at A.
// - saving to nonvolatile store takes about 25 ms, serial input locked meanwhile.
// - ready output signals completion of a nonvolatile save.
// - decoder handles sixteen instruction codes from the instruction field.
// - write-wiper instruction loads data field into wiper register.
// - top byte 20 hex copies wiper register into nonvolatile store.
// - serial output presents previous frame's word while new word shifts in.
// - after power-on wiper loads the last saved nonvolatile value.
// - nonvolatile wiper entry holds midscale as factory value until saved, other entries zero.
// - preset low forces midscale, its rising edge reloads from store.
// - chip-select strobe without a word repeats last step or shift command.
// - commands step wiper by one or shift it by 6 dB.
// - each frame is a 24-bit instruction, address and data word.
// - write-protect low blocks wiper changes except reloads and preset.
// - serial output released whenever chip select is high.
// - serial output and ready only pull low or release.
// - input bits sampled on serial clock rising edges, MSB first.
// - word decoded and executed only when chip select returns high.
// - non-readback commands pass input stream to output delayed 24 clocks.
// - wiper data in bits D0 to D9, store data sixteen bits.
module swcc_top #(
   parameter SAVE_CYCLES = `SWCC_SAVE_CYCLES
) (
   input wire clock,
   input wire resetn,
   input wire clockEnable,
   input wire spiClk,
   input wire chipSelectN,
   input wire serialIn,
   input wire preset_reload_n,
   input wire writeProtectN,
   output reg sdoOut,
   output reg sdoOutEnN,
   output reg readyOut,
   output reg readyOutEnN,
   output reg [`SWCC_WIPER_BITS-1:0] wiperPosition
);
   // ==========================================
   // states
   localparam [1:0] ST_BOOT = 2'b00;
   localparam [1:0] ST_RUN = 2'b01;
   localparam [1:0] ST_SAVE = 2'b10;

   // ==========================================
   // step and shift arithmetic, shared by new words and repeats
   function [`SWCC_WIPER_BITS-1:0] stepWiper;
      input [3:0] cmd;
      input [`SWCC_WIPER_BITS-1:0] cur;
      begin
         case (cmd)
            `SWCC_CMD_DEC6DB, `SWCC_CMD_DEC6DB_ALL: begin
               stepWiper = {1'b0, cur[`SWCC_WIPER_MSB:1]};
            end
            `SWCC_CMD_INC6DB, `SWCC_CMD_INC6DB_ALL: begin
               // saturate rather than wrap to a low code
               if (cur[`SWCC_WIPER_MSB]) begin
                  stepWiper = `SWCC_FULLSCALE;
               end else if (cur == `SWCC_ZEROSCALE) begin
                  stepWiper = 10'h001;
               end else begin
                  stepWiper = {cur[`SWCC_WIPER_MSB-1:0], 1'b0};
               end
            end
            `SWCC_CMD_DEC1, `SWCC_CMD_DEC1_ALL: begin
               if (cur == `SWCC_ZEROSCALE) begin
                  stepWiper = cur;
               end else begin
                  stepWiper = cur - 10'h001;
               end
            end
            `SWCC_CMD_INC1, `SWCC_CMD_INC1_ALL: begin
               if (cur == `SWCC_FULLSCALE) begin
                  stepWiper = cur;
               end else begin
                  stepWiper = cur + 10'h001;
               end
            end
            default: begin
               stepWiper = cur;
            end
         endcase
      end
   endfunction

   function isStepCmd;
      input [3:0] cmd;
      begin
         isStepCmd = (cmd >= `SWCC_CMD_DEC6DB && cmd <= `SWCC_CMD_DEC1_ALL) ||
            (cmd >= `SWCC_CMD_INC6DB);
      end
   endfunction

   // ==========================================
   // pin synchronisers
   wire [4:0] pinSync;
   wire spiClkS;
   wire csNS;
   wire sdiS;
   wire presetNS;
   wire wpNS;

   swcc_sync #(
      .WIDTH(5),
      // link clock resets to its idle low level, so no false edge follows reset
      .INIT(5'h0b)
   ) pinSyncInst (
      .clock(clock),
      .resetn(resetn),
      .clockEnable(clockEnable),
      .asyncIn({spiClk, chipSelectN, serialIn, preset_reload_n, writeProtectN}),
      .syncOut(pinSync)
   );

   assign spiClkS = pinSync[4];
   assign csNS = pinSync[3];
   assign sdiS = pinSync[2];
   assign presetNS = pinSync[1];
   assign wpNS = pinSync[0];

   // ==========================================
   // state
   reg [1:0] state_reg;
   reg [`SWCC_WORD_BITS-1:0] shift_reg;
   reg [`SWCC_COUNT_BITS-1:0] bitCount_reg;
   reg [3:0] lastCmd_reg;
   reg repeatOk_reg;
   reg spiClkPrev_reg;
   reg csNPrev_reg;
   reg presetNPrev_reg;
   reg storeWrite_reg;
   reg [`SWCC_ADDR_BITS-1:0] storeAddr_reg;
   reg [`SWCC_STORE_BITS-1:0] storeData_reg;

   wire storeBusy;
   wire [`SWCC_STORE_BITS-1:0] storeReadData;
   wire [`SWCC_WIPER_BITS-1:0] savedWiper;

   wire spiRise = spiClkS & ~spiClkPrev_reg;
   wire csFall = ~csNS & csNPrev_reg;
   wire csRise = csNS & ~csNPrev_reg;
   wire presetRise = presetNS & ~presetNPrev_reg;
   wire locked = storeBusy | storeWrite_reg | (state_reg == ST_SAVE);
   wire wordFull = (bitCount_reg >= 6'h18);
   wire [3:0] wordCmd = shift_reg[`SWCC_CMD_MSB:`SWCC_CMD_LSB];
   wire [`SWCC_ADDR_BITS-1:0] wordAddr = shift_reg[`SWCC_ADDR_MSB:`SWCC_ADDR_LSB];
   wire [`SWCC_STORE_BITS-1:0] wordData = shift_reg[`SWCC_DATA_MSB:`SWCC_DATA_LSB];
   wire writeOk = wpNS;

   // ==========================================
   // nonvolatile store
   swcc_nvstore #(
      .SAVE_CYCLES(SAVE_CYCLES)
   ) storeInst (
      .clock(clock),
      .resetn(resetn),
      .clockEnable(clockEnable),
      .writeStart(storeWrite_reg),
      .writeAddr(storeAddr_reg),
      .writeData(storeData_reg),
      .readAddr(wordAddr),
      .readData(storeReadData),
      .savedWiper(savedWiper),
      .busy(storeBusy)
   );

   // ==========================================
   // serial frame, decode and wiper control
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_BOOT;
         shift_reg <= 24'h000000;
         bitCount_reg <= 6'h00;
         lastCmd_reg <= `SWCC_CMD_NOP;
         repeatOk_reg <= 1'b0;
         spiClkPrev_reg <= 1'b0;
         csNPrev_reg <= 1'b1;
         presetNPrev_reg <= 1'b1;
         storeWrite_reg <= 1'b0;
         storeAddr_reg <= 4'h0;
         storeData_reg <= 16'h0000;
         wiperPosition <= `SWCC_MIDSCALE;
         sdoOut <= 1'b0;
         sdoOutEnN <= 1'b1;
         readyOut <= 1'b0;
         readyOutEnN <= 1'b1;
      end else if (clockEnable) begin
         spiClkPrev_reg <= spiClkS;
         csNPrev_reg <= csNS;
         presetNPrev_reg <= presetNS;
         storeWrite_reg <= 1'b0;
         // open drain: only ever pull low
         sdoOut <= 1'b0;
         readyOut <= 1'b0;
         sdoOutEnN <= csNS | shift_reg[`SWCC_CMD_MSB];
         readyOutEnN <= ~locked;

         case (state_reg)
            ST_BOOT: begin
               wiperPosition <= savedWiper;
               state_reg <= ST_RUN;
            end
            ST_SAVE: begin
               // shift register locked, frames dropped
               if (!storeBusy && !storeWrite_reg) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (csFall) begin
                  bitCount_reg <= 6'h00;
               end else if (!csNS && spiRise) begin
                  shift_reg <= {shift_reg[`SWCC_WORD_BITS-2:0], sdiS};
                  if (bitCount_reg != `SWCC_COUNT_MAX) begin
                     bitCount_reg <= bitCount_reg + 6'h01;
                  end
               end else if (csRise && bitCount_reg == 6'h00) begin
                  if (repeatOk_reg && writeOk) begin
                     wiperPosition <= stepWiper(lastCmd_reg, wiperPosition);
                  end
               end else if (csRise && wordFull) begin
                  bitCount_reg <= 6'h00;
                  repeatOk_reg <= isStepCmd(wordCmd);
                  lastCmd_reg <= wordCmd;
                  case (wordCmd)
                     `SWCC_CMD_NOP: begin
                        lastCmd_reg <= `SWCC_CMD_NOP;
                     end
                     `SWCC_CMD_RESTORE, `SWCC_CMD_RELOAD: begin
                        wiperPosition <= savedWiper;
                     end
                     `SWCC_CMD_SAVE: begin
                        if (writeOk) begin
                           storeWrite_reg <= 1'b1;
                           storeAddr_reg <= `SWCC_WIPER_ADDR;
                           storeData_reg <= {6'h00, wiperPosition};
                           state_reg <= ST_SAVE;
                        end
                     end
                     `SWCC_CMD_STORE_DATA: begin
                        if (writeOk) begin
                           storeWrite_reg <= 1'b1;
                           storeAddr_reg <= wordAddr;
                           storeData_reg <= wordData;
                           state_reg <= ST_SAVE;
                        end
                     end
                     `SWCC_CMD_READ_STORE: begin
                        shift_reg <= {shift_reg[`SWCC_CMD_MSB:`SWCC_ADDR_LSB], storeReadData};
                     end
                     `SWCC_CMD_READ_WIPER: begin
                        shift_reg <= {shift_reg[`SWCC_CMD_MSB:`SWCC_ADDR_LSB], 6'h00, wiperPosition};
                     end
                     `SWCC_CMD_WRITE_WIPER: begin
                        if (writeOk) begin
                           wiperPosition <= wordData[`SWCC_WIPER_MSB:0];
                        end
                     end
                     default: begin
                        if (writeOk) begin
                           wiperPosition <= stepWiper(wordCmd, wiperPosition);
                        end
                     end
                  endcase
               end else if (csRise) begin
                  // short frame: discarded without effect
                  bitCount_reg <= 6'h00;
               end
            end
            default: begin
               state_reg <= ST_RUN;
            end
         endcase

         // preset pin overrides serial activity, write-protect does not apply
         if (!presetNS) begin
            wiperPosition <= `SWCC_MIDSCALE;
         end else if (presetRise) begin
            wiperPosition <= savedWiper;
         end
      end
   end
endmodule // swcc_top

// [swcc_top_bench.sv]
`timescale 1ns/1ps
module swcc_top_bench;
   localparam int SAVE = 400;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic presetN = 1'b1;
   logic wpN = 1'b1;
   logic clkEn = 1'b1;
   wire spiClk, chipSelectN, serialIn, sdoOut, sdoOutEnN, readyOut, readyOutEnN;
   wire [9:0] wiperPosition;
   wire sdoLine = sdoOutEnN ? 1'b1 : sdoOut;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [23:0] rx;
   logic [23:0] stepWord [11] = '{24'hb00005, 24'he00000, 24'hffffff, 24'hf00000, 24'h600000, 24'h700000,
      24'hc00000, 24'hd00000, 24'hffffff, 24'h400000, 24'h500000};
   logic [9:0] stepExp [11] = '{10'h005, 10'h006, 10'h007, 10'h008, 10'h007, 10'h006, 10'h00c, 10'h018, 10'h030,
      10'h018, 10'h00c};
   always #20 clock = ~clock;
   swcc_top #(.SAVE_CYCLES(SAVE)) dut_u (.clock(clock), .resetn(resetn), .clockEnable(clkEn), .spiClk(spiClk),
      .chipSelectN(chipSelectN), .serialIn(serialIn), .preset_reload_n(presetN), .writeProtectN(wpN),
      .sdoOut(sdoOut), .sdoOutEnN(sdoOutEnN), .readyOut(readyOut), .readyOutEnN(readyOutEnN),
      .wiperPosition(wiperPosition));
   swcc_host host_u (.clock(clock), .sdoLine(sdoLine), .spiClk(spiClk), .chipSelectN(chipSelectN),
      .serialIn(serialIn));
   // ==========================================
   // checking and ending
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // bounded wait, a save that never ends shows up as a mismatch
   task automatic wait_ready();
      int n;
      n = 0;
      while (readyOutEnN !== 1'b1 && n < 600) begin
         host_u.tick(1);
         n++;
      end
      check({23'h0, readyOutEnN}, 24'h1);
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (20) @(posedge clock);
      #1 resetn = 1'b1;
      host_u.tick(6);
      check(wiperPosition, 10'h200);
      check({22'h0, sdoOutEnN, readyOutEnN}, 24'h3);
      $display("test reset done");
      host_u.xfer(24'hb00100, rx);
      check(wiperPosition, 10'h100);
      host_u.xfer(24'hb003ff, rx);
      check(wiperPosition, 10'h3ff);
      check(rx, 24'hb00100);
      host_u.xfer(24'hb00100, rx);
      host_u.xfer(24'h200000, rx);
      check(rx, 24'hb00100);
      check({23'h0, readyOutEnN}, 24'h0);
      host_u.xfer(24'hb00300, rx);
      check(wiperPosition, 10'h100);
      wait_ready();
      $display("test write and save done");
      host_u.xfer(24'hb00000, rx);
      check(wiperPosition, 10'h000);
      presetN = 1'b0;
      host_u.tick(6);
      check(wiperPosition, 10'h200);
      presetN = 1'b1;
      host_u.tick(6);
      check(wiperPosition, 10'h100);
      host_u.xfer(24'hb00000, rx);
      resetn = 1'b0;
      host_u.tick(3);
      resetn = 1'b1;
      host_u.tick(6);
      check(wiperPosition, 10'h100);
      $display("test preset and power-on done");
      host_u.xfer(24'ha00000, rx);
      host_u.xfer(24'h900000, rx);
      check(rx, 24'ha00100);
      host_u.xfer(24'h321234, rx);
      check(rx, 24'h900100);
      wait_ready();
      host_u.xfer(24'h920000, rx);
      host_u.xfer(24'h000000, rx);
      check(rx, 24'h921234);
      $display("test readback done");
      for (int i = 0; i < 11; i++) begin
         if (stepWord[i] === 24'hffffff)
            host_u.strobe();
         else
            host_u.xfer(stepWord[i], rx);
         check(wiperPosition, stepExp[i]);
      end
      $display("test steps done");
      // a whole frame sent while the clock enable is low must leave no trace
      clkEn = 1'b0;
      host_u.xfer(24'hb00123, rx);
      clkEn = 1'b1;
      host_u.tick(4);
      check(wiperPosition, 10'h00c);
      $display("test freeze done");
      wpN = 1'b0;
      host_u.tick(4);
      host_u.xfer(24'hb00050, rx);
      host_u.xfer(24'he00000, rx);
      host_u.strobe();
      host_u.xfer(24'h200000, rx);
      check({23'h0, readyOutEnN}, 24'h1);
      check(wiperPosition, 10'h00c);
      host_u.xfer(24'h100000, rx);
      check(wiperPosition, 10'h100);
      host_u.xfer(24'h000000, rx);
      wpN = 1'b1;
      host_u.tick(4);
      host_u.xfer(24'hb00000, rx);
      wpN = 1'b0;
      host_u.tick(4);
      host_u.xfer(24'h800000, rx);
      check(wiperPosition, 10'h100);
      host_u.xfer(24'h000000, rx);
      wpN = 1'b1;
      $display("test protect done");
      final_report();
   end
   // whole run is near 7000 clocks, limit is about seven times that
   initial begin
      #2000000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end
endmodule // swcc_top_bench

// [swcc_top_props.sv]
`timescale 1ns/1ps
// ==========================================
// port checker
module swcc_top_chk #(
   parameter SAVE_CYCLES = 20
) (
   input wire clock,
   input wire resetn,
   input wire chipSelectN,
   input wire preset_reload_n,
   input wire writeProtectN,
   input wire sdoOut,
   input wire sdoOutEnN,
   input wire readyOut,
   input wire readyOutEnN,
   input wire [9:0] wiperPosition
);
   // ==========================================
   // ages of the last frame end and pin event; cleared by reset so the power-on reload is allowed
   reg [3:0] csAge_reg;
   reg [3:0] evtAge_reg;
   reg [31:0] busyCnt_reg;
   reg csPrev_reg;
   reg presetPrev_reg;
   wire csRose = chipSelectN & ~csPrev_reg;
   wire presetMoved = preset_reload_n ^ presetPrev_reg;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         csAge_reg <= 4'h0;
         evtAge_reg <= 4'h0;
         busyCnt_reg <= 32'h0;
         csPrev_reg <= 1'b1;
         presetPrev_reg <= 1'b1;
      end else begin
         csPrev_reg <= chipSelectN;
         presetPrev_reg <= preset_reload_n;
         csAge_reg <= csRose ? 4'h0 : csAge_reg + {3'h0, csAge_reg != 4'hf};
         evtAge_reg <= (csRose || presetMoved) ? 4'h0
            : evtAge_reg + {3'h0, evtAge_reg != 4'hf};
         busyCnt_reg <= readyOutEnN ? 32'h0 : busyCnt_reg + 32'h1;
      end
   end
   // ==========================================
   // properties
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   chk_sdo_pull_low: assert property (sdoOut == 1'b0) else $error("serial output driven high");
   chk_rdy_pull_low: assert property (readyOut == 1'b0) else $error("ready driven high");
   chk_sdo_released: assert property (chipSelectN [*5] |-> sdoOutEnN)
      else $error("serial output driven while deselected");
   chk_wiper_cause: assert property ($changed(wiperPosition) |-> evtAge_reg <= 4'h8)
      else $error("wiper moved without frame end or preset");
   chk_save_frozen: assert property ((!readyOutEnN && preset_reload_n) [*8] |-> $stable(wiperPosition))
      else $error("wiper moved during save");
   chk_save_span: assert property ($rose(readyOutEnN) |->
      busyCnt_reg >= SAVE_CYCLES && busyCnt_reg <= SAVE_CYCLES + 5)
      else $error("save busy span wrong");
   chk_busy_cause: assert property ($fell(readyOutEnN) |-> csAge_reg <= 4'h6)
      else $error("busy without frame end");
   chk_preset_mid: assert property ((!preset_reload_n) [*5] |-> wiperPosition == 10'h200)
      else $error("preset low not midscale");
   cov_save: cover property ($fell(readyOutEnN));
   cov_preset: cover property ((!preset_reload_n) [*5]);
   cov_protect: cover property ($rose(chipSelectN) && !writeProtectN);
endmodule // swcc_top_chk

bind swcc_top swcc_top_chk #(.SAVE_CYCLES(SAVE_CYCLES)) chk_u (.clock(clock), .resetn(resetn),
   .chipSelectN(chipSelectN), .preset_reload_n(preset_reload_n), .writeProtectN(writeProtectN), .sdoOut(sdoOut),
   .sdoOutEnN(sdoOutEnN), .readyOut(readyOut), .readyOutEnN(readyOutEnN), .wiperPosition(wiperPosition));
